// >>> rtc_evt_map.svh
// offsets, field positions, reset values and counts of the event block
// assumes inclusion by the package and the design file only
`ifndef RTC_EVT_MAP_SVH
`define RTC_EVT_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CONTROL    8'h00
`define OFS_STATUS     8'h04
`define OFS_INTR_CFG   8'h08
`define OFS_SNAP_SUB   8'h0C
`define OFS_SNAP_TIME  8'h10
`define OFS_SNAP_DATE  8'h14
`define OFS_SCRATCH    8'h20
`define SCRATCH_WORDS  20
// ----------------------------------------
// status bit positions
// ----------------------------------------
`define POS_SNAP_FLAG  0
`define POS_SNAP_OVF   1
`define POS_INTR_FLAG  2
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define RST_CONTROL    8'h00
`define RST_INTR_CFG   12'h000
`define RST_SCRATCH    32'h00000000
`define SNAP_DELAY_TICKS 2
`endif

// >>> rtc_evt_pkg.sv
// types shared by the event block
// assumes the map header is on the include path
`include "rtc_evt_map.svh"
package rtc_evt_pkg;
  // ----------------------------------------
  // control fields, high bit first
  // ----------------------------------------
  typedef struct packed {
    logic       alarm_pin_drive_type;
    logic       alarm_out_invert;
    logic [1:0] alarm_out_select;
    logic       refclk_rate_select;
    logic       refclk_out_enable;
    logic       snap_irq_enable;
    logic       snap_enable;
  } ctrl_t;
  typedef struct packed {
    logic       intrusion_pullup_off;
    logic [1:0] intrusion_precharge_len;
    logic [2:0] intrusion_sample_rate;
    logic [1:0] intrusion_filter_count;
    logic       snap_on_intrusion;
    logic       intrusion_irq_enable;
    logic       intrusion_active_level;
    logic       intrusion_input_enable;
  } intr_cfg_t;
  typedef struct packed {
    logic [31:0] subsecond;
    logic [31:0] time_val;
    logic [31:0] date_val;
  } cal_t;
  typedef enum logic [1:0] {
    FS_WAIT   = 2'b00,
    FS_PRECH  = 2'b01,
    FS_SAMPLE = 2'b10
  } filt_state_t;
endpackage : rtc_evt_pkg

// >>> rtc_event_capture_and_outputs.sv
// snapshot capture, intrusion detection, scratch words and shared output pin
// assumes calendar, prescaler counts and alarm flags come from logic on mclk
// What this block does
// RULE1 - snapshots are taken only while snap_enable is set
// RULE2 - a snapshot event copies subsecond, time and date and sets snap_flag
// RULE3 - snap_flag with snap_irq_enable raises the snapshot interrupt
// RULE4 - event while flag set sets overflow and keeps the earlier snapshot
// RULE5 - snap_flag is set two prescaler ticks after the event
// RULE6 - overflow is set at once; software polls it after snap_flag
// RULE7 - event coinciding with a flag clear leaves both flags set
// RULE8 - software clears snap_flag only after reading it as one
// RULE9 - intrusion may trigger a snapshot; its flag sets with snap or overflow
// RULE10 - software selects snap_on_intrusion when pins are shared in filtered mode
// RULE11 - twenty 32-bit scratch words, cleared by backup reset or intrusion
// RULE12 - every intrusion event clears all scratch words
// RULE13 - intrusion watched only when enabled; sets flag and optional interrupt
// RULE14 - filter zero detects rising or falling edge, pull-up off
// RULE15 - edge input gated by enable, so an active pin fires on enabling
// RULE16 - software re-enables the intrusion input before rewriting scratch words
// RULE17 - filtered mode detects after 2, 4 or 8 matching samples
// RULE18 - filtered mode precharges before each sample unless pull-up is off
// RULE19 - refclk with rate select clear is slow clock over 64
// RULE20 - refclk with rate select set is slow clock over 256 times async divide
// RULE21 - alarm output is the selected flag, inverted when invert is set
// RULE22 - an enabled alarm output owns the shared pin over the refclk
// RULE23 - select 00 off, 01 alarm A, 10 alarm B, 11 wakeup flag
// RULE24 - the three flags clear on a written zero, a written one keeps them
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_evt_map.svh"
module rtc_event_capture_and_outputs (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic                 bkp_rst_b,
  input  wire logic [7:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic [31:0]               rdata,
  input  wire logic                 prescaler_tick,
  input  wire logic [6:0]           async_count,
  input  wire logic [14:0]          sync_count,
  input  wire logic                 shift_pending,
  input  wire rtc_evt_pkg::cal_t    cal_in,
  input  wire logic                 alarm_a_flag,
  input  wire logic                 alarm_b_flag,
  input  wire logic                 wakeup_flag,
  input  wire logic                 snap_pin_in,
  input  wire logic                 intrusion_pin_in,
  output logic                      intrusion_pullup_en,
  output logic                      shared_func_pin_out,
  output logic                      shared_func_pin_oe,
  output logic                      snap_irq,
  output logic                      intrusion_irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  rtc_evt_pkg::ctrl_t      ctrl_reg;
  rtc_evt_pkg::intr_cfg_t  icfg_reg;
  rtc_evt_pkg::cal_t       snap_reg;
  rtc_evt_pkg::filt_state_t fstate_reg;
  logic [31:0] scratch_reg [`SCRATCH_WORDS];
  logic        snap_flag_reg, snap_ovf_reg, intr_flag_reg;
  logic        pend_reg, pend_intr_reg;
  logic [1:0]  pend_cnt_reg;
  logic        snap_s1_reg, snap_s2_reg, snap_prev_reg;
  logic        intr_s1_reg, intr_s2_reg, gate_prev_reg;
  logic [3:0]  match_cnt_reg;
  logic [7:0]  period_cnt_reg;
  logic [3:0]  prech_cnt_reg;
  logic        refclk_reg;
  logic        status_wr, busy, trig, capture, ovf_set, set_flag;
  logic        gated, edge_det, filt_det, intr_evt, intr_delay, intr_set;
  logic        sample_match, alarm_on, alarm_val, scr_hit;
  logic [3:0]  need;
  logic [7:0]  scr_off;
  logic [4:0]  scr_idx;
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // second stage feeds every reader; first stage is read by nothing else
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      snap_s1_reg <= 1'b0;
      snap_s2_reg <= 1'b0;
      intr_s1_reg <= 1'b0;
      intr_s2_reg <= 1'b0;
    end else begin
      snap_s1_reg <= snap_pin_in;
      snap_s2_reg <= snap_s1_reg;
      intr_s1_reg <= intrusion_pin_in;
      intr_s2_reg <= intr_s1_reg;
    end
  end
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  assign status_wr = wr && (addr == `OFS_STATUS);
  assign scr_off   = addr - `OFS_SCRATCH;
  assign scr_idx   = scr_off[6:2];
  // the top offset bit is checked too, so high addresses do not alias words
  assign scr_hit   = (addr >= `OFS_SCRATCH) && (scr_idx < 5'(`SCRATCH_WORDS))
                     && !scr_off[7] && (scr_off[1:0] == 2'h0);
  // control and intrusion configuration words
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `RST_CONTROL;
      icfg_reg <= `RST_INTR_CFG;
    end else if (wr && addr == `OFS_CONTROL) begin
      ctrl_reg <= wdata[7:0];
    end else if (wr && addr == `OFS_INTR_CFG) begin
      icfg_reg <= wdata[11:0];
    end
  end
  // read data stands the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      unique case (addr)
        `OFS_CONTROL:   rdata <= {24'h000000, ctrl_reg};
        `OFS_STATUS:    rdata <= {29'h00000000, intr_flag_reg, snap_ovf_reg, snap_flag_reg};
        `OFS_INTR_CFG:  rdata <= {20'h00000, icfg_reg};
        `OFS_SNAP_SUB:  rdata <= snap_reg.subsecond;
        `OFS_SNAP_TIME: rdata <= snap_reg.time_val;
        `OFS_SNAP_DATE: rdata <= snap_reg.date_val;
        default:        rdata <= scr_hit ? scratch_reg[scr_idx] : 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
  // ----------------------------------------
  // snapshot trigger
  // ----------------------------------------
  // the delay window counts as busy, so overflow can lead the flag
  assign busy     = snap_flag_reg || pend_reg;
  assign trig     = ctrl_reg.snap_enable && ((snap_s2_reg && !snap_prev_reg)  // [RULE1]
                    || (intr_evt && icfg_reg.snap_on_intrusion));            // [RULE9]
  assign capture  = trig && !busy;                                          // [RULE2]
  assign ovf_set  = trig && busy;                                           // [RULE4] [RULE6]
  assign set_flag = pend_reg && prescaler_tick
                    && (pend_cnt_reg == 2'(`SNAP_DELAY_TICKS - 1));         // [RULE5]
  // snapshot words are frozen while busy, so overflow keeps the old ones
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      snap_reg      <= '0;
      snap_prev_reg <= 1'b0;
    end else begin
      snap_prev_reg <= snap_s2_reg;
      if (capture) begin
        snap_reg <= cal_in;                                                 // [RULE2] [RULE4]
      end
    end
  end
  // delay of two prescaler ticks before the flag shows
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg      <= 1'b0;
      pend_intr_reg <= 1'b0;
      pend_cnt_reg  <= 2'h0;
    end else if (capture) begin
      pend_reg      <= 1'b1;
      pend_intr_reg <= intr_delay;
      pend_cnt_reg  <= 2'h0;
    end else if (set_flag) begin
      pend_reg      <= 1'b0;
      pend_intr_reg <= 1'b0;
    end else if (pend_reg && prescaler_tick) begin
      pend_cnt_reg  <= pend_cnt_reg + 2'h1;                                 // [RULE5]
    end
  end
  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // a set in the cycle of a clearing write wins over the clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      snap_flag_reg <= 1'b0;
      snap_ovf_reg  <= 1'b0;
      intr_flag_reg <= 1'b0;
    end else begin
      if (set_flag || ovf_set) begin
        snap_flag_reg <= snap_flag_reg || set_flag;                         // [RULE7]
      end else if (status_wr && !wdata[`POS_SNAP_FLAG]) begin
        snap_flag_reg <= 1'b0;                                              // [RULE24]
      end
      if (ovf_set) begin
        snap_ovf_reg <= 1'b1;                                               // [RULE6] [RULE7]
      end else if (status_wr && !wdata[`POS_SNAP_OVF]) begin
        snap_ovf_reg <= 1'b0;                                               // [RULE24]
      end
      if (intr_set) begin
        intr_flag_reg <= 1'b1;                                              // [RULE13]
      end else if (status_wr && !wdata[`POS_INTR_FLAG]) begin
        intr_flag_reg <= 1'b0;                                              // [RULE24]
      end
    end
  end
  // interrupt levels
  assign snap_irq      = snap_flag_reg && ctrl_reg.snap_irq_enable;         // [RULE3]
  assign intrusion_irq = intr_flag_reg && icfg_reg.intrusion_irq_enable;    // [RULE13]
  // ----------------------------------------
  // intrusion detection
  // ----------------------------------------
  // active level folded to high, then anded with enable before the edge
  assign gated    = icfg_reg.intrusion_input_enable
                    && (intr_s2_reg ^ icfg_reg.intrusion_active_level);     // [RULE14] [RULE15]
  assign edge_det = (icfg_reg.intrusion_filter_count == 2'h0) && gated && !gate_prev_reg;
  assign need     = 4'h1 << icfg_reg.intrusion_filter_count;                // [RULE17]
  assign sample_match = intr_s2_reg ^ icfg_reg.intrusion_active_level;     // [RULE17]
  assign filt_det = (fstate_reg == rtc_evt_pkg::FS_SAMPLE) && sample_match
                    && (match_cnt_reg == need - 4'h1);                      // [RULE17]
  assign intr_evt = icfg_reg.intrusion_input_enable && (edge_det || filt_det); // [RULE13]
  // with snapshot linkage a fresh capture holds the flag back to match snap_flag
  assign intr_delay = intr_evt && icfg_reg.snap_on_intrusion && ctrl_reg.snap_enable && !busy;
  assign intr_set   = (intr_evt && !intr_delay) || (set_flag && pend_intr_reg); // [RULE9]
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gate_prev_reg <= 1'b0;
    end else begin
      gate_prev_reg <= gated;
    end
  end
  // sampler: wait a period, precharge, sample once
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fstate_reg     <= rtc_evt_pkg::FS_WAIT;
      period_cnt_reg <= 8'h00;
      prech_cnt_reg  <= 4'h0;
    end else if (!icfg_reg.intrusion_input_enable || icfg_reg.intrusion_filter_count == 2'h0) begin
      fstate_reg     <= rtc_evt_pkg::FS_WAIT;
      period_cnt_reg <= 8'h00;
    end else begin
      unique case (fstate_reg)
        rtc_evt_pkg::FS_WAIT: begin
          if (prescaler_tick) begin
            period_cnt_reg <= period_cnt_reg + 8'h01;
            if (period_cnt_reg >= (8'h01 << icfg_reg.intrusion_sample_rate) - 8'h01) begin
              period_cnt_reg <= 8'h00;
              prech_cnt_reg  <= 4'h0;
              fstate_reg     <= icfg_reg.intrusion_pullup_off ? rtc_evt_pkg::FS_SAMPLE
                                                              : rtc_evt_pkg::FS_PRECH;
            end
          end
        end
        rtc_evt_pkg::FS_PRECH: begin
          if (prescaler_tick) begin
            prech_cnt_reg <= prech_cnt_reg + 4'h1;
            if (prech_cnt_reg == (4'h1 << icfg_reg.intrusion_precharge_len) - 4'h1) begin
              fstate_reg <= rtc_evt_pkg::FS_SAMPLE;                         // [RULE18]
            end
          end
        end
        rtc_evt_pkg::FS_SAMPLE: fstate_reg <= rtc_evt_pkg::FS_WAIT;
        default:                fstate_reg <= rtc_evt_pkg::FS_WAIT;
      endcase
    end
  end
  // consecutive match count saturates, so a held level fires only once
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      match_cnt_reg <= 4'h0;
    end else if (icfg_reg.intrusion_filter_count == 2'h0 || !icfg_reg.intrusion_input_enable) begin
      match_cnt_reg <= 4'h0;
    end else if (fstate_reg == rtc_evt_pkg::FS_SAMPLE) begin
      if (!sample_match) begin
        match_cnt_reg <= 4'h0;
      end else if (match_cnt_reg < need) begin
        match_cnt_reg <= match_cnt_reg + 4'h1;                              // [RULE17]
      end
    end
  end
  // pull-up only during precharge; never in edge mode
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      intrusion_pullup_en <= 1'b0;
    end else begin
      intrusion_pullup_en <= (icfg_reg.intrusion_filter_count != 2'h0)      // [RULE14]
                             && !icfg_reg.intrusion_pullup_off
                             && (fstate_reg == rtc_evt_pkg::FS_PRECH);      // [RULE18]
    end
  end
  // ----------------------------------------
  // scratch words, backup domain
  // ----------------------------------------
  // survive system reset; intrusion clear beats a same-cycle write
  generate
    for (genvar i = 0; i < `SCRATCH_WORDS; i++) begin : g_scratch
      always_ff @(posedge mclk or negedge bkp_rst_b) begin
        if (!bkp_rst_b) begin
          scratch_reg[i] <= `RST_SCRATCH;                                   // [RULE11]
        end else if (intr_evt) begin
          scratch_reg[i] <= `RST_SCRATCH;                                   // [RULE12]
        end else if (wr && scr_hit && scr_idx == 5'(i)) begin
          scratch_reg[i] <= wdata;                                          // [RULE11]
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // shared output pin
  // ----------------------------------------
  // shift_pending is not read here, so the 1 Hz form has no jitter from it on either edge
  always_comb begin
    alarm_val = 1'b0;
    unique case (ctrl_reg.alarm_out_select)
      2'h0: alarm_val = 1'b0;
      2'h1: alarm_val = alarm_a_flag;                                       // [RULE23]
      2'h2: alarm_val = alarm_b_flag;
      2'h3: alarm_val = wakeup_flag;
    endcase
  end
  assign alarm_on = (ctrl_reg.alarm_out_select != 2'h0);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      refclk_reg          <= 1'b0;
      shared_func_pin_out <= 1'b0;
      shared_func_pin_oe  <= 1'b0;
    end else begin
      refclk_reg <= ctrl_reg.refclk_rate_select ? sync_count[7]            // [RULE20]
                                                : async_count[5];           // [RULE19]
      if (alarm_on) begin
        shared_func_pin_out <= ctrl_reg.alarm_pin_drive_type ? 1'b0
                               : (alarm_val ^ ctrl_reg.alarm_out_invert);   // [RULE21]
        shared_func_pin_oe  <= !ctrl_reg.alarm_pin_drive_type
                               || !(alarm_val ^ ctrl_reg.alarm_out_invert); // [RULE22]
      end else begin
        shared_func_pin_out <= refclk_reg;
        shared_func_pin_oe  <= ctrl_reg.refclk_out_enable;                  // [RULE19]
      end
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_snap_gate;
    @(posedge mclk) disable iff (!rst_b) $rose(pend_reg) |-> $past(ctrl_reg.snap_enable);
  endproperty
  a_snap_gate: assert property (p_snap_gate) else $error("capture while disabled"); // [RULE1]
  property p_snap_copy;
    @(posedge mclk) disable iff (!rst_b) capture |=> snap_reg.time_val == $past(cal_in.time_val);
  endproperty
  a_snap_copy: assert property (p_snap_copy) else $error("time not captured"); // [RULE2]
  property p_snap_irq;
    @(posedge mclk) disable iff (!rst_b)
      $rose(snap_flag_reg) && ctrl_reg.snap_irq_enable |-> snap_irq;
  endproperty
  a_snap_irq: assert property (p_snap_irq) else $error("snapshot irq missing"); // [RULE3]
  property p_ovf_keep;
    @(posedge mclk) disable iff (!rst_b) ovf_set |=> snap_ovf_reg && $stable(snap_reg);
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow altered snapshot"); // [RULE4]
  property p_flag_delay;
    @(posedge mclk) disable iff (!rst_b)
      $rose(snap_flag_reg) |-> $past(prescaler_tick) && $past(pend_cnt_reg) == 2'h1;
  endproperty
  a_flag_delay: assert property (p_flag_delay) else $error("flag delay wrong"); // [RULE5]
  property p_coincide;
    @(posedge mclk) disable iff (!rst_b)
      ovf_set && snap_flag_reg && status_wr && !wdata[0] |=> snap_flag_reg && snap_ovf_reg;
  endproperty
  a_coincide: assert property (p_coincide) else $error("coincident event lost"); // [RULE7]
  property p_scratch_clr;
    @(posedge mclk) disable iff (!rst_b || !bkp_rst_b) intr_evt |=> scratch_reg[0] == 32'h0;
  endproperty
  a_scratch_clr: assert property (p_scratch_clr) else $error("scratch not cleared"); // [RULE12]
  property p_edge_pullup;
    @(posedge mclk) disable iff (!rst_b)
      icfg_reg.intrusion_filter_count == 2'h0 ##1 icfg_reg.intrusion_filter_count == 2'h0
      |-> !intrusion_pullup_en;
  endproperty
  a_edge_pullup: assert property (p_edge_pullup) else $error("pull-up on in edge mode"); // [RULE14]
  property p_alarm_pin;
    @(posedge mclk) disable iff (!rst_b)
      alarm_on && !ctrl_reg.alarm_pin_drive_type |=> shared_func_pin_oe
      && shared_func_pin_out == $past(alarm_val ^ ctrl_reg.alarm_out_invert);
  endproperty
  a_alarm_pin: assert property (p_alarm_pin) else $error("alarm not on pin"); // [RULE22]
endmodule : rtc_event_capture_and_outputs
`default_nettype wire

// >>> ext_pins.sv
// far-side model: snapshot and intrusion pins plus the async prescaler source
// assumes the bench sets the wanted pin levels on snap_level and intr_level
`timescale 1ns/1ps
`default_nettype none
module ext_pins (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       snap_level,
  input  wire logic       intr_level,
  output wire logic       snap_pin_in,
  output wire logic       intrusion_pin_in,
  output wire logic       prescaler_tick,
  output logic [6:0]      async_count,
  output logic [14:0]     sync_count
);
  // free-running prescaler, one tick every four cycles
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) async_count <= 7'h00;
    else async_count <= async_count + 7'h01;
  end
  assign prescaler_tick = (async_count[1:0] == 2'h3);
  // sync prescaler advances once per tick; bit 7 is the slow reference
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync_count <= 15'h0000;
    end else if (prescaler_tick) begin
      sync_count <= sync_count + 15'h0001;
    end
  end
  // pins move off the clock edge, as a truly asynchronous source would
  assign #3 snap_pin_in = snap_level;
  assign #3 intrusion_pin_in = intr_level;
endmodule : ext_pins
`default_nettype wire

// >>> tb_rtc_event_capture_and_outputs.sv
// self-checking bench for the event block
// assumes ext_pins as far side; backup reset has its own bench signal
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_event_capture_and_outputs;
  logic              mclk, rst_b, bkp_rst_b, wr, rd, snap_level, intr_level, fa, fb, fw;
  logic [14:0]       scnt;
  logic [7:0]        addr;
  logic [31:0]       wdata, rdata, rv;
  logic              pu, pout, poe, s_irq, i_irq, s_pin, i_pin, tick;
  logic [6:0]        acnt;
  rtc_evt_pkg::cal_t cal;
  int                num_errors, total_checks, n;
  rtc_event_capture_and_outputs i_rtc_event_capture_and_outputs (.mclk(mclk), .rst_b(rst_b),
    .bkp_rst_b(bkp_rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .prescaler_tick(tick), .async_count(acnt), .sync_count(scnt), .shift_pending(1'b0),
    .cal_in(cal), .alarm_a_flag(fa), .alarm_b_flag(fb), .wakeup_flag(fw),
    .snap_pin_in(s_pin), .intrusion_pin_in(i_pin), .intrusion_pullup_en(pu),
    .shared_func_pin_out(pout), .shared_func_pin_oe(poe), .snap_irq(s_irq),
    .intrusion_irq(i_irq));
  ext_pins i_ext_pins (.mclk(mclk), .rst_b(rst_b), .snap_level(snap_level),
    .intr_level(intr_level), .snap_pin_in(s_pin), .intrusion_pin_in(i_pin),
    .prescaler_tick(tick), .async_count(acnt), .sync_count(scnt));
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    addr <= a; rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : rd_reg
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic pulse_snap;
    snap_level <= 1'b1;
    repeat (6) @(posedge mclk);
    snap_level <= 1'b0;
  endtask : pulse_snap
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_snap;
    pulse_snap();
    repeat (20) @(posedge mclk);
    rd_reg(8'h04); chk("ignored", 32'h0, rv);
    wr_reg(8'h00, 32'h3);
    snap_level <= 1'b1;
    rd_reg(8'h04); chk("early flag", 32'h0, rv);
    snap_level <= 1'b0;
    n = 0;
    do begin rd_reg(8'h04); n++; end while (rv[0] !== 1'b1 && n < 20);
    chk("flag", 32'h1, rv);
    chk("irq", 32'h1, {31'h0, s_irq});
    rd_reg(8'h10); chk("time", cal.time_val, rv);
    rd_reg(8'h0C); chk("sub", cal.subsecond, rv);
    cal.time_val = 32'h00000777;
    pulse_snap();
    repeat (20) @(posedge mclk);
    rd_reg(8'h04); chk("ovf", 32'h3, rv);
    rd_reg(8'h10); chk("kept", 32'h00123456, rv);
    // event edge and clearing write meet at the third edge from here
    snap_level <= 1'b1;
    @(posedge mclk);
    wr_reg(8'h04, 32'h0);
    snap_level <= 1'b0;
    rd_reg(8'h04); chk("coincide", 32'h3, rv);
    wr_reg(8'h04, 32'h7); rd_reg(8'h04); chk("w1 keeps", 32'h3, rv);
    wr_reg(8'h04, 32'h0); rd_reg(8'h04); chk("w0 clears", 32'h0, rv);
  endtask : t_snap
  // pin already active when enabled must fire and wipe scratch
  task automatic t_intr;
    wr_reg(8'h24, 32'h5A5A5A5A);
    // system reset alone; the backup domain must keep the word
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    rd_reg(8'h24); chk("scratch", 32'h5A5A5A5A, rv);
    intr_level <= 1'b1;
    wr_reg(8'h08, 32'h5);
    repeat (10) @(posedge mclk);
    rd_reg(8'h04); chk("intr flag", 32'h4, rv);
    chk("intr irq", 32'h1, {31'h0, i_irq});
    rd_reg(8'h24); chk("wiped", 32'h0, rv);
    wr_reg(8'h08, 32'h0);
    wr_reg(8'h04, 32'h0);
    intr_level <= 1'b0;
    repeat (4) @(posedge mclk);
    wr_reg(8'h08, 32'h5);
    wr_reg(8'h24, 32'h0000C0DE);
    rd_reg(8'h24); chk("rewrite", 32'h0000C0DE, rv);
    rd_reg(8'hA4); chk("alias", 32'h0, rv);
    // filtered level with snapshot linkage: both flags show together
    wr_reg(8'h00, 32'h1);
    wr_reg(8'h08, 32'h19);
    intr_level <= 1'b1;
    n = 0;
    repeat (60) begin @(posedge mclk); #1 if (pu) n++; end
    chk("precharge", 32'h1, 32'(n > 0));
    rd_reg(8'h04); chk("filt flags", 32'h5, rv);
    rd_reg(8'h24); chk("filt wipe", 32'h0, rv);
    wr_reg(8'h08, 32'h0);
    wr_reg(8'h04, 32'h0);
    intr_level <= 1'b0;
  endtask : t_intr
  task automatic t_out;
    logic pv;
    // two full periods of each reference form; settle first so the switch is not counted
    for (int c = 0; c < 2; c++) begin
      wr_reg(8'h00, c ? 32'hC : 32'h4);
      repeat (4) @(posedge mclk);
      #1 pv = pout;
      n = 0;
      repeat (c ? 2048 : 128) begin @(posedge mclk); #1 if (pout && !pv) n++; pv = pout; end
      chk("refclk rises", 32'd2, n);
    end
    for (int s = 1; s < 4; s++) begin
      {fw, fb, fa} <= 3'(1 << (s - 1));
      wr_reg(8'h00, 32'h44 | (s << 4));
      repeat (3) @(posedge mclk);
      chk("alarm inv", 32'h2, {30'h0, poe, pout});
      {fw, fb, fa} <= 3'h0;
      repeat (3) @(posedge mclk);
      chk("alarm idle", 32'h3, {30'h0, poe, pout});
    end
    // open drain: drives only a low level, releases otherwise
    fa <= 1'b1;
    wr_reg(8'h00, 32'hD4);
    repeat (3) @(posedge mclk);
    chk("drain low", 32'h2, {30'h0, poe, pout});
    fa <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("drain off", 32'h0, {30'h0, poe, pout});
    wr_reg(8'h00, 32'h0);
    repeat (3) @(posedge mclk);
    chk("pin off", 32'h0, {31'h0, poe});
  endtask : t_out
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // watchdog: the tests need far fewer than 20000 cycles
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
  initial begin
    {rst_b, bkp_rst_b, wr, rd, snap_level, intr_level, fa, fb, fw} = 9'h000;
    addr = 8'h00; wdata = 32'h0; num_errors = 0; total_checks = 0;
    cal = {32'h00000ABC, 32'h00123456, 32'h00210101};
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    bkp_rst_b <= 1'b1;
    rd_reg(8'h08); chk("cfg rst", 32'h0, rv);
    rd_reg(8'h18); chk("unmapped", 32'h0, rv);
    t_snap();
    t_intr();
    t_out();
    end_sim();
  end
endmodule : tb_rtc_event_capture_and_outputs
`default_nettype wire
